/* design/sfs_pkg.sv */
// Purpose: Constants shared by the sensor fault safe-state output block.
// Assumes: 25 MHz system clock on mclk.
// Notes: Register map for the APB slave and protocol/mode encodings.
package sfs_pkg;
    // Clock rate and derived timing
    localparam int unsigned CLK_HZ = 25000000;
    localparam int unsigned REPORT_MS = 5;          // Fault must reach host within this
    localparam int unsigned FRAME_MS = 1;           // Longest allowed transmission
    localparam int unsigned REPORT_CYC = CLK_HZ / 1000 * REPORT_MS;
    localparam int unsigned FRAME_CYC = CLK_HZ / 1000 * FRAME_MS;
    localparam int unsigned BOOT_WIN_US = 100;      // Programming entry window after start-up
    localparam int unsigned BOOT_WIN_CYC = CLK_HZ / 1000000 * BOOT_WIN_US;

    // Output protocol selection, fixed at manufacture
    typedef enum logic [1:0] {
        SFS_PROTO_PWM = 2'h0,
        SFS_PROTO_CONT = 2'h1,
        SFS_PROTO_TRIG = 2'h2
    } sfs_proto_e;

    // Status nibble bit positions
    localparam int unsigned ST_WARN_BIT = 2;
    localparam int unsigned ST_ERR_BIT = 3;

    // APB register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_ANGLE = 8'h08;
    localparam logic [7:0] ADDR_FRAME = 8'h0c;

    // CTRL fields
    localparam int unsigned CTRL_PP_BIT = 0;         // 1: push-pull drive
    localparam int unsigned CTRL_EN_BIT = 1;         // Transmission enable
    localparam logic [31:0] CTRL_RST_VAL = 32'h0000_0003;

    // STATUS fields
    localparam int unsigned STAT_FLT_BIT = 0;
    localparam int unsigned STAT_OV_BIT = 1;
    localparam int unsigned STAT_RSTIND_BIT = 2;
    localparam int unsigned STAT_PROG_BIT = 3;
    localparam int unsigned STAT_VALID_BIT = 4;
    localparam int unsigned STAT_LONG_BIT = 5;

    // Frame length in cycles, default inside the 1 ms bound
    localparam logic [15:0] FRAME_LEN_RST = 16'd10000;
    localparam logic [7:0] PROG_CMD = 8'ha5;
endpackage : sfs_pkg

/* design/sfs_sync.sv */
// Purpose: Three-stage synchroniser with agreement filter for pin inputs.
// Assumes: Input is asynchronous to mclk.
// Notes: Output changes only when stages two and three agree.
`timescale 1ns/10ps
module sfs_sync #(
    parameter logic RST_VAL = 1'b0
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic din,
    output logic dout
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic out_q;

    // First stage feeds only the second
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            s1_q <= RST_VAL;
            s2_q <= RST_VAL;
            s3_q <= RST_VAL;
            out_q <= RST_VAL;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                out_q <= s3_q;
            end
        end
    end

    assign dout = out_q;
endmodule : sfs_sync

/* design/sfs_apb.sv */
// Purpose: APB slave for the safe-state block registers.
// Assumes: 32-bit APB3, zero wait states.
// Notes: Unmapped addresses read zero and answer pslverr.
`timescale 1ns/10ps
module sfs_apb (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] stat_word,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [31:0] ctrl,
    output logic [11:0] angle,
    output logic [15:0] frame_len
);
    import sfs_pkg::*;

    logic [31:0] ctrl_q;
    logic [11:0] angle_q;
    logic [15:0] frame_q;
    wire acc = psel & penable;
    wire hit_ctrl = (paddr == ADDR_CTRL);
    wire hit_stat = (paddr == ADDR_STATUS);
    wire hit_ang = (paddr == ADDR_ANGLE);
    wire hit_frm = (paddr == ADDR_FRAME);
    wire mapped = hit_ctrl | hit_stat | hit_ang | hit_frm;

    // Writes land at the access phase only
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ctrl_q <= CTRL_RST_VAL;
            angle_q <= 12'h000;
            frame_q <= FRAME_LEN_RST;
        end else if (acc && pwrite) begin
            if (hit_ctrl) ctrl_q <= pwdata;
            if (hit_ang) angle_q <= pwdata[11:0];
            if (hit_frm) frame_q <= pwdata[15:0];
        end
    end

    // Read mux, narrow fields sit low
    assign prdata = !acc ? 32'h0 : hit_ctrl ? {30'h0, ctrl_q[1:0]} : hit_stat ? stat_word :
                    hit_ang ? {20'h0, angle_q} : hit_frm ? {16'h0, frame_q} : 32'h0;
    assign pready = 1'b1;
    assign pslverr = acc & ~mapped;
    assign ctrl = ctrl_q;
    assign angle = angle_q;
    assign frame_len = frame_q;
endmodule : sfs_apb

/* design/sfs_top.sv */
// Purpose: Fault signalling and output-line control for an angle sensor.
// Assumes: Supply comparators and output pin arrive asynchronously.
// Notes: Frame formats are outside; this block emits a framed status nibble.
// The start-up window belongs to programming only, so no frame starts inside it.
// A missed report deadline is only shown in status: the host owns the polling rate.
// Operation
// - Report faults via status bit or diag duty
// - Reach safe state on error
// - Hold indication while fault lasts, once minimum
// - Clear indication when fault gone
// - Indicate fault to host within 5 ms
// - Keep each transmission within 1 ms (a longer frame_len is only flagged in status)
// - Angle valid only without supply faults
// - Undervoltage forces reset
// - Overvoltage tristates output, stops protocol
// - Output pin overvoltage also flags overvoltage
// - Interrupted exchange recovers without lockup
// - Driver selectable push-pull or open-drain (triggered mode ignores the CTRL bit and is always open-drain)
// - Push-pull drives both levels
// - Triggered mode releases line when high
// - Programming entry only right after start-up
// - Protocol fixed at manufacture
// - Outputs high impedance during reset
// - Report reset after returning to operation
`timescale 1ns/10ps
module sfs_top #(
    parameter sfs_pkg::sfs_proto_e PROTO = sfs_pkg::SFS_PROTO_TRIG,
    parameter int unsigned BOOT_WIN = sfs_pkg::BOOT_WIN_CYC,
    parameter int unsigned REPORT_LIMIT = sfs_pkg::REPORT_CYC
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic uv_det,
    input wire logic ov_det,
    input wire logic pin_ov_det,
    input wire logic int_fault,
    input wire logic sensor_output_pin_i,
    output logic sensor_output_pin_o,
    output logic sensor_output_pin_oe,
    output logic [3:0] status_nibble,
    output logic [11:0] angle_out,
    output logic angle_valid,
    output logic prog_mode,
    output logic sys_rst_req
);
    import sfs_pkg::*;

    typedef enum logic [1:0] {
        SFS_IDLE = 2'b00,
        SFS_LOW = 2'b01,
        SFS_HIGH = 2'b11
    } sfs_tx_e;

    logic uv_s, ov_s, pov_s, pin_s;
    logic [31:0] ctrl;
    logic [11:0] angle;
    logic [15:0] frame_len;
    logic [31:0] stat_word;
    logic [31:0] rd_data;
    logic rd_ready, rd_err;

    // Comparator levels share one synchroniser shape; each bit still runs its own instance and filter,
    // so one comparator can be seen a cycle or more before the others
    logic [2:0] cmp_raw;
    logic [2:0] cmp_s;
    assign cmp_raw = {pin_ov_det, ov_det, uv_det};
    for (genvar gi = 0; gi < 3; gi++) begin : g_cmp_sync
        sfs_sync #(.RST_VAL(1'b0)) u_sync (
            .mclk(mclk),
            .nrst(nrst),
            .din(cmp_raw[gi]),
            .dout(cmp_s[gi])
        );
    end
    assign uv_s = cmp_s[0];
    assign ov_s = cmp_s[1];
    assign pov_s = cmp_s[2];

    // The line idles high on its pull-up, so the filter starts high: no false edge after reset
    sfs_sync #(.RST_VAL(1'b1)) u_pin (.mclk(mclk), .nrst(nrst), .din(sensor_output_pin_i), .dout(pin_s));

    sfs_apb u_apb (
        .mclk(mclk),
        .nrst(nrst),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .stat_word(stat_word),
        .prdata(rd_data),
        .pready(rd_ready),
        .pslverr(rd_err),
        .ctrl(ctrl),
        .angle(angle),
        .frame_len(frame_len)
    );

    // Fault combination
    wire ov_any = ov_s | pov_s;
    wire fault_now = ov_any | int_fault;
    wire trig_mode = (PROTO == SFS_PROTO_TRIG);
    wire push_pull = ctrl[CTRL_PP_BIT] & ~trig_mode;

    logic flt_q, flt_d;
    logic rstind_q, rstind_d;
    logic prog_q;
    logic boot_done_q;
    logic [$clog2(BOOT_WIN+1)-1:0] boot_cnt_q;
    logic [$clog2(REPORT_LIMIT+1)-1:0] rep_cnt_q;
    logic long_q;
    logic rep_late_q;
    logic [7:0] low_len_q;
    logic [15:0] tx_cnt_q;
    sfs_tx_e tx_q, tx_d;
    logic pin_prev_q;
    logic [7:0] cmd_sh_q;
    logic [2:0] cmd_bits_q;
    logic o_q, oe_q;
    logic [3:0] nib_q;
    logic [11:0] ang_q;
    logic val_q, rst_req_q;

    wire frame_end = (tx_q == SFS_HIGH) && (tx_cnt_q == 16'h0000);
    wire host_trig = pin_prev_q & ~pin_s;
    wire start_tx = ~ov_any & ~prog_q & boot_done_q & ctrl[CTRL_EN_BIT] &
                    (trig_mode ? host_trig : 1'b1);

    // Sticky fault: set wins, cleared only after a frame carried it
    assign flt_d = fault_now | (flt_q & ~frame_end);
    // Reset indication sent once after coming back
    assign rstind_d = rstind_q & ~frame_end;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            flt_q <= 1'b0;
            rstind_q <= 1'b1;
        end else begin
            flt_q <= flt_d;
            rstind_q <= rstind_d;
        end
    end

    // Start-up window for programming command
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            boot_cnt_q <= '0;
            boot_done_q <= 1'b0;
        end else if (!boot_done_q) begin
            boot_cnt_q <= boot_cnt_q + 1'b1;
            boot_done_q <= (boot_cnt_q == ($clog2(BOOT_WIN+1))'(BOOT_WIN - 1));
        end
    end

    // Command decode: each low pulse on the line is one bit, a long pulse is a one.
    // Low time is measured on the synchronised level, so the filter lag falls on
    // both edges and cancels; the threshold sits well clear of either pulse length.
    localparam int unsigned BIT_LONG_CYC = 16;
    wire line_rose = ~pin_prev_q & pin_s;
    wire cmd_bit = (low_len_q >= 8'(BIT_LONG_CYC));
    wire cmd_full = (cmd_bits_q == 3'h7) & line_rose;
    wire [7:0] cmd_next = {cmd_sh_q[6:0], cmd_bit};

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pin_prev_q <= 1'b1;
            low_len_q <= 8'h00;
            cmd_sh_q <= 8'h00;
            cmd_bits_q <= 3'h0;
            prog_q <= 1'b0;
        end else begin
            pin_prev_q <= pin_s;
            if (host_trig) begin
                low_len_q <= 8'h00;
            end else if (!pin_s && low_len_q != 8'hff) begin
                low_len_q <= low_len_q + 8'h01;                // Saturates on a stuck-low line
            end
            if (!boot_done_q && !prog_q && line_rose) begin
                cmd_sh_q <= cmd_next;
                cmd_bits_q <= cmd_bits_q + 3'h1;
            end
            if (!boot_done_q && cmd_full && cmd_next == PROG_CMD) begin
                prog_q <= 1'b1;
            end
        end
    end

    // Transmit sequencer; a frame ends by count or on overvoltage, no host action can stall it
    always_comb begin
        tx_d = tx_q;
        unique case (tx_q)
            SFS_IDLE: if (start_tx) tx_d = SFS_LOW;
            SFS_LOW: if (ov_any) tx_d = SFS_IDLE; else if (tx_cnt_q == 16'h0000) tx_d = SFS_HIGH;
            SFS_HIGH: if (ov_any || tx_cnt_q == 16'h0000) tx_d = SFS_IDLE;
            default: tx_d = SFS_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            tx_q <= SFS_IDLE;
            tx_cnt_q <= 16'h0000;
        end else begin
            tx_q <= tx_d;
            if (tx_q != tx_d) begin
                tx_cnt_q <= {1'b0, frame_len[15:1]};
            end else if (tx_cnt_q != 16'h0000) begin
                tx_cnt_q <= tx_cnt_q - 16'h0001;
            end
        end
    end

    // Report-latency watchdog and frame length check
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rep_cnt_q <= '0;
            long_q <= 1'b0;
        end else begin
            long_q <= (frame_len > 16'(FRAME_CYC));
            if (!flt_q || frame_end) begin
                rep_cnt_q <= '0;
            end else if (rep_cnt_q != ($clog2(REPORT_LIMIT+1))'(REPORT_LIMIT)) begin
                rep_cnt_q <= rep_cnt_q + 1'b1;
            end
        end
    end

    // Deadline miss: the host stopped polling while a fault waited. Nothing here
    // can push a frame out in triggered mode, so the miss is only made visible.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rep_late_q <= 1'b0;
        end else begin
            rep_late_q <= (rep_cnt_q == ($clog2(REPORT_LIMIT+1))'(REPORT_LIMIT));
        end
    end

    // Pin drive: tristate on overvoltage or programming; open-drain releases high
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            o_q <= 1'b0;
            oe_q <= 1'b0;
        end else begin
            o_q <= (tx_d == SFS_HIGH);
            if (ov_any || prog_q) begin
                oe_q <= 1'b0;
            end else if (push_pull) begin
                oe_q <= 1'b1;
            end else begin
                oe_q <= (tx_d == SFS_LOW);
            end
        end
    end

    // Status nibble and angle outputs
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            nib_q <= 4'h0;
            ang_q <= 12'h000;
            val_q <= 1'b0;
            rst_req_q <= 1'b0;
        end else begin
            nib_q <= {rstind_q, flt_q, 2'b00};
            val_q <= ~ov_any & ~uv_s & ~prog_q;
            ang_q <= (ov_any | uv_s) ? 12'h000 : angle;
            rst_req_q <= uv_s;
        end
    end

    // Status word; the deadline flag sits just above the documented fields
    assign stat_word = {25'h0, rep_late_q, long_q, val_q, prog_q, rstind_q, ov_any, flt_q};
    assign prdata = rd_data;
    assign pready = rd_ready;
    assign pslverr = rd_err;
    assign sensor_output_pin_o = o_q;
    assign sensor_output_pin_oe = oe_q;
    assign status_nibble = nib_q;
    assign angle_out = ang_q;
    assign angle_valid = val_q;
    assign prog_mode = prog_q;
    assign sys_rst_req = rst_req_q;
endmodule : sfs_top

/* verif/sfs_host.sv */
// Purpose: Host controller model on the shared sensor output line.
// Assumes: Line has an external pull-up; host only ever pulls low.
// Notes: Wire level is the AND of all parties, as on a real open-drain net.
`timescale 1ns/10ps
module sfs_host (
    input wire logic drv_o,
    input wire logic drv_oe,
    input wire logic pull_low,
    output logic line
);
    // Released sensor reads high via pull-up; host trigger pulls low
    // Programming bits are plain low pulses from the host, long for a one
    assign line = (drv_oe ? drv_o : 1'b1) & ~pull_low;
endmodule : sfs_host

/* verif/sfs_top_chk.sv */
// Purpose: Concurrent checks on the safe-state block ports.
// Assumes: Comparator inputs pass a three-flop synchroniser.
// Notes: Repetition counts leave room for that synchroniser lag.
`timescale 1ns/10ps
module sfs_chk
    import sfs_pkg::*;
#(
    parameter int unsigned BOOT_WIN = 50
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic uv_det,
    input wire logic ov_det,
    input wire logic pin_ov_det,
    input wire logic int_fault,
    input wire logic sensor_output_pin_o,
    input wire logic sensor_output_pin_oe,
    input wire logic [3:0] status_nibble,
    input wire logic angle_valid,
    input wire logic prog_mode,
    input wire logic sys_rst_req
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    logic [15:0] boot_cnt_q;
    // Cycles since reset release, saturating so a long run never wraps
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            boot_cnt_q <= 16'h0000;
        end else if (boot_cnt_q != 16'hffff) begin
            boot_cnt_q <= boot_cnt_q + 16'h0001;
        end
    end
    sequence s_ov_held; ov_det [*8]; endsequence
    sequence s_pin_ov_held; pin_ov_det [*8]; endsequence
    property p_rst_hiz; $rose(nrst) |-> (!sensor_output_pin_oe) [*2]; endproperty
    a_rst_hiz: assert property (p_rst_hiz) else $error("line driven at reset exit");
    property p_od_release; sensor_output_pin_oe && sensor_output_pin_o |=> !sensor_output_pin_oe; endproperty
    a_od_release: assert property (p_od_release) else $error("line not released when high");
    property p_ov_tri; s_ov_held |-> !sensor_output_pin_oe; endproperty
    a_ov_tri: assert property (p_ov_tri) else $error("line driven during overvoltage");
    property p_pin_ov; s_pin_ov_held |-> !sensor_output_pin_oe; endproperty
    a_pin_ov: assert property (p_pin_ov) else $error("line driven during pin overvoltage");
    property p_uv_rst; uv_det [*6] |-> sys_rst_req; endproperty
    a_uv_rst: assert property (p_uv_rst) else $error("no reset on undervoltage");
    property p_uv_clr; (!uv_det) [*6] |-> !sys_rst_req; endproperty
    a_uv_clr: assert property (p_uv_clr) else $error("reset request without undervoltage");
    property p_supply_invalid; (uv_det || ov_det) [*6] |-> !angle_valid; endproperty
    a_supply_invalid: assert property (p_supply_invalid) else $error("angle valid on bad supply");
    property p_fault_shown; $rose(int_fault) |-> ##[1:1000] status_nibble[ST_WARN_BIT]; endproperty
    a_fault_shown: assert property (p_fault_shown) else $error("fault never shown");
    property p_prog_win; $rose(prog_mode) |-> 32'(boot_cnt_q) <= BOOT_WIN + 32'd8; endproperty
    a_prog_win: assert property (p_prog_win) else $error("programming entered late");
    property p_prog_hiz; prog_mode |=> !sensor_output_pin_oe; endproperty
    a_prog_hiz: assert property (p_prog_hiz) else $error("line driven in programming mode");
endmodule : sfs_chk
bind sfs_top sfs_chk #(.BOOT_WIN(BOOT_WIN)) u_chk (.mclk(mclk), .nrst(nrst), .uv_det(uv_det),
    .ov_det(ov_det), .pin_ov_det(pin_ov_det), .int_fault(int_fault), .sensor_output_pin_o(sensor_output_pin_o),
    .sensor_output_pin_oe(sensor_output_pin_oe), .status_nibble(status_nibble), .angle_valid(angle_valid),
    .prog_mode(prog_mode), .sys_rst_req(sys_rst_req));

/* verif/sfs_top_tb.sv */
// Purpose: Self-checking bench for the safe-state output block.
// Assumes: Triggered protocol; frame length shortened to 100 cycles.
// Notes: APB results are queued by the driver and compared by a monitor.
`timescale 1ns/10ps
module sfs_top_tb;
    import sfs_pkg::*;
    typedef struct {logic [31:0] data; logic [31:0] mask; logic err;} sfs_note_s;
    logic mclk, nrst, psel, penable, pwrite, pslverr, pready, uv_det, ov_det, pin_ov_det, int_fault;
    logic pin_o, pin_oe, line, pull_low, angle_valid, prog_mode, sys_rst_req;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rnd;
    logic [3:0] status_nibble;
    logic [11:0] angle_out;
    sfs_note_s notes[$];
    sfs_note_s cur;
    int errors = 0;
    int compares = 0;
    sfs_top #(.BOOT_WIN(400), .REPORT_LIMIT(2000)) dut (.mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .uv_det(uv_det), .ov_det(ov_det), .pin_ov_det(pin_ov_det), .int_fault(int_fault),
        .sensor_output_pin_i(line), .sensor_output_pin_o(pin_o), .sensor_output_pin_oe(pin_oe),
        .status_nibble(status_nibble), .angle_out(angle_out), .angle_valid(angle_valid),
        .prog_mode(prog_mode), .sys_rst_req(sys_rst_req));
    sfs_host u_host (.drv_o(pin_o), .drv_oe(pin_oe), .pull_low(pull_low), .line(line));
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next
    task automatic give_verdict();
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : give_verdict
    task automatic chk_bit(input string nm, input logic exp, input logic got);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %b seen %b", nm, exp, got);
        end
    endtask : chk_bit
    // One APB transfer; the note is queued before the request goes out
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                       input logic er);
        int n;
        notes.push_back('{d, m, er});
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            errors++;
            give_verdict();
        end
    endtask : apb
    // Host trigger pulse: line pulled low for 8 cycles, then released
    task automatic trigger();
        @(posedge mclk);
        pull_low <= 1'b1;
        repeat (8) @(posedge mclk);
        pull_low <= 1'b0;
    endtask : trigger
    // Programming command: one low pulse per bit, first bit lands highest
    task automatic send_cmd(input logic [7:0] c);
        for (int i = 7; i >= 0; i--) begin
            @(posedge mclk);
            pull_low <= 1'b1;
            repeat (c[i] ? 24 : 6) @(posedge mclk);
            pull_low <= 1'b0;
            repeat (6) @(posedge mclk);
        end
    endtask : send_cmd
    task automatic wait_bit(input int idx, input logic exp, input string nm);
        int n;
        n = 0;
        while (status_nibble[idx] !== exp && n < 600) begin
            @(posedge mclk);
            n++;
        end
        chk_bit(nm, exp, status_nibble[idx]);
        if (n >= 600) give_verdict();
    endtask : wait_bit
    // Monitor: the oldest note meets each completed access phase
    always @(posedge mclk) begin
        if (psel && penable && pready) begin
            cur = notes.pop_front();
            compares++;
            if ((prdata & cur.mask) !== (cur.data & cur.mask) || pslverr !== cur.err) begin
                errors++;
                $display("MISMATCH apb 0x%h expected %h/%b seen %h/%b", paddr, cur.data, cur.err, prdata, pslverr);
            end
        end
    end
    initial begin
        {nrst, psel, penable, pwrite, uv_det, ov_det, pin_ov_det, int_fault, pull_low} = '0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        rnd = 32'h995087b9;
        repeat (10) @(posedge mclk);
        chk_bit("oe in reset", 1'b0, pin_oe);
        repeat (10) @(posedge mclk);
        nrst <= 1'b1;
        apb(1'b0, ADDR_CTRL, CTRL_RST_VAL, 32'hffff_ffff, 1'b0);
        apb(1'b0, ADDR_FRAME, {16'h0000, FRAME_LEN_RST}, 32'hffff_ffff, 1'b0);
        apb(1'b0, ADDR_STATUS, 32'h0000_0004, 32'h0000_0004, 1'b0);
        apb(1'b1, 8'h10, 32'h1234_5678, 32'h0000_0000, 1'b1);
        apb(1'b0, 8'h10, 32'h0000_0000, 32'hffff_ffff, 1'b1);
        apb(1'b1, ADDR_FRAME, 32'h0000_0064, 32'h0000_0000, 1'b0);
        apb(1'b0, ADDR_FRAME, 32'h0000_0064, 32'h0000_ffff, 1'b0);
        rnd = lfsr_next(rnd);
        apb(1'b1, ADDR_ANGLE, rnd, 32'h0000_0000, 1'b0);
        apb(1'b0, ADDR_ANGLE, rnd, 32'h0000_0fff, 1'b0);
        trigger();
        wait_bit(ST_ERR_BIT, 1'b1, "reset shown");
        repeat (150) @(posedge mclk);
        int_fault <= 1'b1;
        @(posedge mclk);
        int_fault <= 1'b0;
        trigger();
        wait_bit(ST_WARN_BIT, 1'b1, "brief fault shown");
        repeat (2) begin
            repeat (150) @(posedge mclk);
            trigger();
        end
        wait_bit(ST_WARN_BIT, 1'b0, "fault cleared");
        repeat (150) @(posedge mclk);
        ov_det <= 1'b1;
        repeat (10) @(posedge mclk);
        trigger();
        repeat (20) @(posedge mclk);
        chk_bit("oe overvoltage", 1'b0, pin_oe);
        chk_bit("valid overvoltage", 1'b0, angle_valid);
        apb(1'b0, ADDR_STATUS, 32'h0000_0002, 32'h0000_0002, 1'b0);
        ov_det <= 1'b0;
        pin_ov_det <= 1'b1;
        repeat (10) @(posedge mclk);
        chk_bit("oe pin overvoltage", 1'b0, pin_oe);
        pin_ov_det <= 1'b0;
        uv_det <= 1'b1;
        repeat (10) @(posedge mclk);
        chk_bit("uv reset", 1'b1, sys_rst_req);
        uv_det <= 1'b0;
        repeat (200) @(posedge mclk);
        trigger();
        repeat (30) @(posedge mclk);
        trigger();
        repeat (200) @(posedge mclk);
        trigger();
        chk_bit("frame after abort", 1'b1, pin_oe);
        apb(1'b0, ADDR_STATUS, 32'h0000_0000, 32'h0000_0008, 1'b0);
        repeat (200) @(posedge mclk);
        nrst <= 1'b0;
        repeat (3) @(posedge mclk);
        chk_bit("oe mid reset", 1'b0, pin_oe);
        nrst <= 1'b1;
        wait_bit(ST_ERR_BIT, 1'b1, "reset shown again");
        send_cmd(PROG_CMD);
        repeat (10) @(posedge mclk);
        chk_bit("prog entered", 1'b1, prog_mode);
        chk_bit("oe in prog", 1'b0, pin_oe);
        repeat (5) @(posedge mclk);
        give_verdict();
    end
endmodule : sfs_top_tb
